// File: core/sfam_monitor.sv
// Purpose: latches drive alarms, applies clearing policy, shows the active code
// Assumes: AHB-Lite single word transfers, causes from same-clock logic,
//   emergency stop from a pin
// Notes: lower code position wins the display when several alarms stand
// How it works
// R1: overtemperature latches code 35 until clear
// R2: stall timed outside torque mode, code 31
// R3: homing input unassigned raises code 39
// R4: current mutation raises collision code 40
// R5: encoder fault code 41 survives clear requests
// R6: non general I/O use raises code 42
// R7: watchdog timeout while enabled, code 43
// R8: host sends message within watchdog timeout
// R9: emergency stop alarm clears on release
// R10: show active code, hold until cleared
`timescale 1ns/100ps
`default_nettype none
module sfam_monitor (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic i_overtemp,
  input wire logic i_stalled,
  input wire logic i_current_spike,
  input wire logic i_encoder_fault,
  input wire logic i_io_misuse,
  input wire logic i_wdog_message,
  input wire logic I_ESTOP_PIN,
  output logic [7:0] o_display_code,
  output logic o_alarm_active,
  output logic o_irq
);
  localparam int N = sfam_pkg::NUM_ALARMS;

  sfam_pkg::sfam_bus_req_type req_q;
  sfam_pkg::sfam_cause_type cause;
  logic [sfam_pkg::CTRL_W-1:0] ctrl_q;
  logic [15:0] stall_limit_q;
  logic [15:0] wdog_limit_q;
  logic [N-1:0] alarm_q;
  logic [N-1:0] set_vec;
  logic [N-1:0] irq_status_q;
  logic [N-1:0] irq_enable_q;
  logic [N-1:0] irq_clear;
  logic [7:0] code_q;
  logic [31:0] rdata_q;
  logic clear_req;
  logic wr_en;
  logic stall_expired;
  logic wdog_expired;
  logic estop_level;
  logic homing_bad;
  logic io_misuse_d;
  logic wdog_run;

  function automatic logic [7:0] code_of(input logic [N-1:0] act);
    logic [7:0] c;
    c = sfam_pkg::CODE_NONE;
    if (act[sfam_pkg::BIT_WATCHDOG]) c = sfam_pkg::CODE_WATCHDOG;
    if (act[sfam_pkg::BIT_IOFUNC]) c = sfam_pkg::CODE_IOFUNC;
    if (act[sfam_pkg::BIT_ENCODER]) c = sfam_pkg::CODE_ENCODER;
    if (act[sfam_pkg::BIT_COLLISION]) c = sfam_pkg::CODE_COLLISION;
    if (act[sfam_pkg::BIT_HOMING]) c = sfam_pkg::CODE_HOMING;
    if (act[sfam_pkg::BIT_OVERTEMP]) c = sfam_pkg::CODE_OVERTEMP;
    if (act[sfam_pkg::BIT_STALL]) c = sfam_pkg::CODE_STALL;
    if (act[sfam_pkg::BIT_ESTOP]) c = sfam_pkg::CODE_ESTOP;
    return c;
  endfunction

  // bus slave: zero wait states, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      req_q <= '0;
    end else if (HREADY) begin
      req_q.sel <= HSEL && HTRANS[1];
      req_q.write <= HWRITE;
      req_q.addr <= HADDR[7:0];
    end
  end

  assign wr_en = req_q.sel && req_q.write;
  assign clear_req = wr_en && (req_q.addr == sfam_pkg::ADDR_CLEAR)
                     && HWDATA[sfam_pkg::CLEAR_REQ_BIT];
  assign irq_clear = (wr_en && (req_q.addr == sfam_pkg::ADDR_IRQ_CLEAR))
                     ? HWDATA[N-1:0] : '0;

  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      ctrl_q <= sfam_pkg::CTRL_RESET;
      stall_limit_q <= sfam_pkg::STALL_LIMIT_RESET;
      wdog_limit_q <= sfam_pkg::WDOG_LIMIT_RESET;
      irq_enable_q <= '0;
    end else if (wr_en) begin
      case (req_q.addr)
        sfam_pkg::ADDR_CTRL: ctrl_q <= HWDATA[sfam_pkg::CTRL_W-1:0];
        sfam_pkg::ADDR_STALL_LIMIT: stall_limit_q <= HWDATA[15:0];
        sfam_pkg::ADDR_WDOG_LIMIT: wdog_limit_q <= HWDATA[15:0];
        sfam_pkg::ADDR_IRQ_ENABLE: irq_enable_q <= HWDATA[N-1:0];
        default: ;
      endcase
    end
  end

  // read data registered in the address phase, valid in the data phase
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (HREADY && HSEL && HTRANS[1] && !HWRITE) begin
      case (HADDR[7:0])
        sfam_pkg::ADDR_CTRL: rdata_q <= {26'h000_0000, ctrl_q};
        sfam_pkg::ADDR_STALL_LIMIT: rdata_q <= {16'h0000, stall_limit_q};
        sfam_pkg::ADDR_WDOG_LIMIT: rdata_q <= {16'h0000, wdog_limit_q};
        sfam_pkg::ADDR_ALARMS: rdata_q <= {24'h00_0000, alarm_q};
        sfam_pkg::ADDR_CODE: rdata_q <= {24'h00_0000, code_q};
        sfam_pkg::ADDR_IRQ_STATUS: rdata_q <= {24'h00_0000, irq_status_q};
        sfam_pkg::ADDR_IRQ_ENABLE: rdata_q <= {24'h00_0000, irq_enable_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  sfam_sync u_estop_sync (
    .i_clk(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_pin(I_ESTOP_PIN),
    .o_level(estop_level)
  );

  assign cause.overtemp = i_overtemp;
  assign cause.stall = i_stalled;
  assign cause.collision = i_current_spike;
  assign cause.encoder_fault = i_encoder_fault;
  assign cause.io_misuse = i_io_misuse;
  assign cause.wdog_message = i_wdog_message;
  assign cause.estop = estop_level;

  // R2: stall timer off in torque mode
  sfam_ms_timer #(
    .CYCLES_PER_MS(sfam_pkg::CYCLES_PER_MS)
  ) u_stall_timer (
    .i_clk(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_run(cause.stall && !ctrl_q[sfam_pkg::CTRL_TORQUE_MODE]),
    .i_limit_ms(stall_limit_q),
    .o_expired(stall_expired)
  );

  // R7: watchdog restarts on each message
  assign wdog_run = ctrl_q[sfam_pkg::CTRL_WDOG_EN] && !cause.wdog_message;
  sfam_ms_timer #(
    .CYCLES_PER_MS(sfam_pkg::CYCLES_PER_MS)
  ) u_wdog_timer (
    .i_clk(I_CLOCK),
    .i_reset_n(I_RESET_N),
    .i_run(wdog_run),
    .i_limit_ms(wdog_limit_q),
    .o_expired(wdog_expired)
  );

  // R3: homing method needs an assigned input
  assign homing_bad =
    (ctrl_q[sfam_pkg::CTRL_HOME_LIMIT] && !ctrl_q[sfam_pkg::CTRL_LIMIT_ASSIGNED]) ||
    (ctrl_q[sfam_pkg::CTRL_HOME_ORIGIN] && !ctrl_q[sfam_pkg::CTRL_ORIGIN_ASSIGNED]);

  // R6: misuse reported by program engine
  assign io_misuse_d = cause.io_misuse;

  always_comb begin
    set_vec = '0;
    // R1: overtemp sets alarm
    set_vec[sfam_pkg::BIT_OVERTEMP] = cause.overtemp;
    set_vec[sfam_pkg::BIT_STALL] = stall_expired;
    set_vec[sfam_pkg::BIT_HOMING] = homing_bad;
    // R4: current mutation sets collision
    set_vec[sfam_pkg::BIT_COLLISION] = cause.collision;
    set_vec[sfam_pkg::BIT_ENCODER] = cause.encoder_fault;
    set_vec[sfam_pkg::BIT_IOFUNC] = io_misuse_d;
    set_vec[sfam_pkg::BIT_WATCHDOG] = wdog_expired;
    set_vec[sfam_pkg::BIT_ESTOP] = cause.estop;
  end

  // R10: alarms held, set beats clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      alarm_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (i == sfam_pkg::BIT_ESTOP) begin
          // R9: follows the released input
          alarm_q[i] <= set_vec[i];
        end else if (i == sfam_pkg::BIT_ENCODER) begin
          // R5: only power-on reset clears
          alarm_q[i] <= alarm_q[i] || set_vec[i];
        end else if (set_vec[i]) begin
          alarm_q[i] <= 1'b1;
        end else if (clear_req) begin
          alarm_q[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt status: rising alarm sets, set wins over clear
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~irq_clear) | (set_vec & ~alarm_q);
    end
  end

  // R10: display register
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) begin
      code_q <= sfam_pkg::CODE_NONE;
    end else begin
      code_q <= code_of(alarm_q);
    end
  end

  assign o_display_code = code_q;
  assign o_alarm_active = (code_q != sfam_pkg::CODE_NONE);
  assign o_irq = |(irq_status_q & irq_enable_q);
endmodule : sfam_monitor
`default_nettype wire

// File: core/sfam_pkg.sv
// Purpose: shared constants and types for the servo fault alarm monitor
// Assumes: 100 MHz clock, AHB-Lite register access
// Notes: alarm codes are the numbers shown on the display
package sfam_pkg;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_ESTOP = 8'h15;
  localparam logic [7:0] CODE_STALL = 8'h1F;
  localparam logic [7:0] CODE_OVERTEMP = 8'h23;
  localparam logic [7:0] CODE_HOMING = 8'h27;
  localparam logic [7:0] CODE_COLLISION = 8'h28;
  localparam logic [7:0] CODE_ENCODER = 8'h29;
  localparam logic [7:0] CODE_IOFUNC = 8'h2A;
  localparam logic [7:0] CODE_WATCHDOG = 8'h2B;
  // alarm bit positions
  localparam int BIT_ESTOP = 0;
  localparam int BIT_STALL = 1;
  localparam int BIT_OVERTEMP = 2;
  localparam int BIT_HOMING = 3;
  localparam int BIT_COLLISION = 4;
  localparam int BIT_ENCODER = 5;
  localparam int BIT_IOFUNC = 6;
  localparam int BIT_WATCHDOG = 7;
  localparam int NUM_ALARMS = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STALL_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_WDOG_LIMIT = 8'h08;
  localparam logic [7:0] ADDR_ALARMS = 8'h0C;
  localparam logic [7:0] ADDR_CODE = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] ADDR_CLEAR = 8'h20;
  // control register fields
  localparam int CTRL_TORQUE_MODE = 0;
  localparam int CTRL_WDOG_EN = 1;
  localparam int CTRL_HOME_LIMIT = 2;
  localparam int CTRL_HOME_ORIGIN = 3;
  localparam int CTRL_LIMIT_ASSIGNED = 4;
  localparam int CTRL_ORIGIN_ASSIGNED = 5;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  // write 1 at bit 0 of the clear register requests alarm clear
  localparam int CLEAR_REQ_BIT = 0;
  // timing: limits counted in milliseconds
  localparam int CLK_MHZ = 100;
  localparam int MS_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [15:0] STALL_LIMIT_RESET = 16'h01F4;
  localparam logic [15:0] WDOG_LIMIT_RESET = 16'h0064;

  typedef struct packed {
    logic overtemp;
    logic stall;
    logic collision;
    logic encoder_fault;
    logic io_misuse;
    logic wdog_message;
    logic estop;
  } sfam_cause_type;

  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } sfam_bus_req_type;
endpackage : sfam_pkg

// File: core/sfam_ms_timer.sv
// Purpose: millisecond duration timer, restarts when its run input drops
// Assumes: same clock domain inputs
// Notes: flags once the elapsed time exceeds the limit
`timescale 1ns/100ps
`default_nettype none
module sfam_ms_timer #(
  parameter int CYCLES_PER_MS = 100000
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_run,
  input wire logic [15:0] i_limit_ms,
  output logic o_expired
);
  logic [16:0] pre_q;
  logic [15:0] ms_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !i_run) begin
      pre_q <= 17'h0_0000;
      ms_q <= 16'h0000;
    end else if (pre_q == 17'(CYCLES_PER_MS - 1)) begin
      pre_q <= 17'h0_0000;
      // saturate so a long stall never wraps back to zero
      if (ms_q != 16'hFFFF) begin
        ms_q <= ms_q + 16'h0001;
      end
    end else begin
      pre_q <= pre_q + 17'h0_0001;
    end
  end

  assign o_expired = i_run && (ms_q > i_limit_ms);
endmodule : sfam_ms_timer
`default_nettype wire

// File: core/sfam_sync.sv
// Purpose: three-stage synchroniser for pin inputs
// Assumes: asynchronous input level
// Notes: output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sfam_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      o_level <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        o_level <= s3_q;
      end
    end
  end
endmodule : sfam_sync
`default_nettype wire

// File: tb/sfam_chk_monitor.sv
// Purpose: port checker for the fault alarm monitor
// Assumes: one clock, sync active low reset
// Notes: cause rules are seen through the alarm outputs
`timescale 1ns/100ps
`default_nettype none
module sfam_chk (
  input wire logic I_CLOCK,
  input wire logic I_RESET_N,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic i_overtemp,
  input wire logic i_current_spike,
  input wire logic i_encoder_fault,
  input wire logic i_io_misuse,
  input wire logic I_ESTOP_PIN,
  input wire logic [7:0] o_display_code,
  input wire logic o_alarm_active
);
  logic enc_q;
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESET_N);
  // only a reset forgets an encoder fault
  always_ff @(posedge I_CLOCK) begin
    if (!I_RESET_N) enc_q <= 1'b0;
    else if (i_encoder_fault) enc_q <= 1'b1;
  end
  chk_bus_zero_wait: assert property (HREADYOUT && !HRESP)
    else $error("bus wait or error");
  chk_active_code: assert property (o_alarm_active == (o_display_code != 8'h00))
    else $error("active flag disagrees with code");
  chk_overtemp_raise: assert property (i_overtemp |-> ##2 o_alarm_active)
    else $error("overtemperature not shown");
  chk_collision_raise: assert property (i_current_spike |-> ##2 o_alarm_active)
    else $error("collision not shown");
  chk_iofunc_raise: assert property (i_io_misuse |-> ##2 o_alarm_active)
    else $error("io misuse not shown");
  chk_encoder_hold: assert property (enc_q |=> o_alarm_active)
    else $error("encoder alarm lost");
  chk_estop_raise: assert property (I_ESTOP_PIN [*8] |=> o_alarm_active)
    else $error("emergency stop not shown");
  chk_estop_release: assert property (
    (!I_ESTOP_PIN) [*8] |-> o_display_code != sfam_pkg::CODE_ESTOP)
    else $error("emergency stop code after release");
endmodule // sfam_chk
bind sfam_monitor sfam_chk sfam_chk_inst (.I_CLOCK(I_CLOCK), .I_RESET_N(I_RESET_N),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .i_overtemp(i_overtemp),
  .i_current_spike(i_current_spike), .i_encoder_fault(i_encoder_fault),
  .i_io_misuse(i_io_misuse), .I_ESTOP_PIN(I_ESTOP_PIN),
  .o_display_code(o_display_code), .o_alarm_active(o_alarm_active));
`default_nettype wire

// File: tb/sfam_host_model.sv
// Purpose: host controller sending the watchdog message
// Assumes: message is a one cycle pulse
// Notes: silent while not enabled
`timescale 1ns/100ps
`default_nettype none
module sfam_host_model #(
  parameter int PERIOD = 1000
) (
  input wire logic i_clk,
  input wire logic i_enable,
  output logic o_message
);
  int count = 0;
  initial o_message = 1'b0;
  always @(posedge i_clk) begin
    count <= (i_enable && count < PERIOD - 1) ? count + 1 : 0;
    o_message <= i_enable && count == PERIOD - 1;
  end
endmodule // sfam_host_model
`default_nettype wire

// File: tb/sfam_monitor_tb_top.sv
// Purpose: register level tests of the fault alarm monitor
// Assumes: zero wait AHB-Lite slave
// Notes: millisecond timers cannot be shortened, limits set to 0 ms
`timescale 1ns/100ps
`default_nettype none
module sfam_monitor_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, irq, active, msg;
  logic [7:0] code;
  logic [2:0] ev = 3'h0;
  logic stall = 1'b0;
  logic enc = 1'b0;
  logic estop = 1'b0;
  logic host_en = 1'b0;
  logic [15:0] alm[3] = '{16'h0004, 16'h0010, 16'h0040};
  logic [15:0] cod[3] = '{16'h0023, 16'h0028, 16'h002A};
  int fails = 0;
  int checks = 0;
  always #5 clk = ~clk;
  sfam_monitor sfam_monitor_inst (.I_CLOCK(clk), .I_RESET_N(rst_n), .HSEL(hsel),
    .HADDR({24'h00_0000, haddr}), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .i_overtemp(ev[0]), .i_stalled(stall), .i_current_spike(ev[1]),
    .i_encoder_fault(enc), .i_io_misuse(ev[2]), .i_wdog_message(msg),
    .I_ESTOP_PIN(estop), .o_display_code(code), .o_alarm_active(active), .o_irq(irq));
  sfam_host_model #(.PERIOD(1000)) sfam_host_model_inst (.i_clk(clk),
    .i_enable(host_en), .o_message(msg));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000);
    check(name, rd, {16'h0000, exp});
  endtask
  task automatic clr;
    bus(1'b1, 8'h20, 16'h0001);
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #1_150_000;
    fails++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rchk("ctrl", 8'h00, 16'h0000);
    rchk("stall limit", 8'h04, 16'h01F4);
    rchk("wdog limit", 8'h08, 16'h0064);
    rchk("unmapped", 8'h40, 16'h0000);
    rchk("code idle", 8'h10, 16'h0000);
    bus(1'b1, 8'h1C, 16'h0004);
    for (int k = 0; k < 3; k++) begin
      ev <= 3'h1 << k;
      @(posedge clk);
      ev <= 3'h0;
      rchk("alarms", 8'h0C, alm[k]);
      rchk("code", 8'h10, cod[k]);
      clr();
      rchk("cleared", 8'h0C, 16'h0000);
    end
    rchk("irq status", 8'h14, 16'h0054);
    check("irq", irq, 32'h0000_0001);
    bus(1'b1, 8'h18, 16'h0004);
    // the clear lands on the edge the task ends on, look once it has settled
    @(negedge clk);
    check("irq masked", irq, 32'h0000_0000);
    ev <= 3'h1;
    clr();
    rchk("held", 8'h0C, 16'h0004);
    ev <= 3'h0;
    clr();
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, 8'h00, 16'h0004 << k);
      rchk("homing", 8'h0C, 16'h0008);
      rchk("homing code", 8'h10, 16'h0027);
      bus(1'b1, 8'h00, 16'h0014 << k);
      clr();
      rchk("homing fixed", 8'h0C, 16'h0000);
    end
    estop <= 1'b1;
    repeat (10) @(posedge clk);
    rchk("estop code", 8'h10, 16'h0015);
    estop <= 1'b0;
    repeat (10) @(posedge clk);
    rchk("estop gone", 8'h0C, 16'h0000);
    bus(1'b1, 8'h04, 16'h0000);
    bus(1'b1, 8'h08, 16'h0000);
    host_en <= 1'b1;
    bus(1'b1, 8'h00, 16'h0002);
    repeat (3000) @(posedge clk);
    rchk("kept alive", 8'h0C, 16'h0000);
    host_en <= 1'b0;
    stall <= 1'b1;
    repeat (50000) @(posedge clk);
    rchk("early", 8'h0C, 16'h0000);
    // both timers expire a little over 100000 cycles after silence begins
    repeat (50200) @(posedge clk);
    rchk("timeouts", 8'h0C, 16'h0082);
    stall <= 1'b0;
    bus(1'b1, 8'h00, 16'h0000);
    clr();
    rchk("timeouts cleared", 8'h0C, 16'h0000);
    enc <= 1'b1;
    @(posedge clk);
    enc <= 1'b0;
    clr();
    rchk("encoder", 8'h0C, 16'h0020);
    rchk("encoder code", 8'h10, 16'h0029);
    conclude();
  end
endmodule // sfam_monitor_tb_top
`default_nettype wire
